/* File: logic/peripheral_pin_router.sv */
// Peripheral pin router: Wishbone control registers and pin steering

// ------------------------------------------------------------------
// Function
// ------------------------------------------------------------------
// Function
// - Control A bit 5 moves logic table one output to its alternative pin.
// - Control A bit 4 moves logic table zero output to its alternative pin.
// - Control A bits 2..0 enable event pins two, one, zero; off when clear.
// - Control B bit 4 moves two-wire signals to alternative pins.
// - Control B bit 2 moves SPI signals to alternative pins.
// - Control B bit 0 moves USART signals to alternative pins.
// - Control C bits 5..3 move timer A outputs 5..3, split mode only.
// - Control C bits 2..0 move timer A outputs 2..0, both modes.
// - Control D bit 1 moves second timer B output to its alternative pin.
// - Control D bit 0 moves first timer B output to its alternative pin.
module peripheral_pin_router
   import pin_router_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Event outputs
   input wire logic [EVENT_LINES-1:0] event_i,
   output logic [EVENT_LINES-1:0] event_pin_o,
   output logic [EVENT_LINES-1:0] event_pin_oe_o,
   // Logic table outputs, bit 0 is table zero
   input wire logic [LUT_LINES-1:0] lut_out_i,
   output logic [LUT_LINES-1:0] lut_def_o,
   output logic [LUT_LINES-1:0] lut_def_oe_o,
   output logic [LUT_LINES-1:0] lut_alt_o,
   output logic [LUT_LINES-1:0] lut_alt_oe_o,
   // Two-wire interface, open drain: out, enable, pin input
   input wire logic [TWI_LINES-1:0] twi_out_i,
   input wire logic [TWI_LINES-1:0] twi_oe_i,
   output logic [TWI_LINES-1:0] twi_in_o,
   input wire logic [TWI_LINES-1:0] twi_def_in_i,
   output logic [TWI_LINES-1:0] twi_def_o,
   output logic [TWI_LINES-1:0] twi_def_oe_o,
   input wire logic [TWI_LINES-1:0] twi_alt_in_i,
   output logic [TWI_LINES-1:0] twi_alt_o,
   output logic [TWI_LINES-1:0] twi_alt_oe_o,
   // SPI
   input wire logic [SPI_LINES-1:0] spi_out_i,
   input wire logic [SPI_LINES-1:0] spi_oe_i,
   output logic [SPI_LINES-1:0] spi_in_o,
   input wire logic [SPI_LINES-1:0] spi_def_in_i,
   output logic [SPI_LINES-1:0] spi_def_o,
   output logic [SPI_LINES-1:0] spi_def_oe_o,
   input wire logic [SPI_LINES-1:0] spi_alt_in_i,
   output logic [SPI_LINES-1:0] spi_alt_o,
   output logic [SPI_LINES-1:0] spi_alt_oe_o,
   // USART
   input wire logic [USART_LINES-1:0] usart_out_i,
   input wire logic [USART_LINES-1:0] usart_oe_i,
   output logic [USART_LINES-1:0] usart_in_o,
   input wire logic [USART_LINES-1:0] usart_def_in_i,
   output logic [USART_LINES-1:0] usart_def_o,
   output logic [USART_LINES-1:0] usart_def_oe_o,
   input wire logic [USART_LINES-1:0] usart_alt_in_i,
   output logic [USART_LINES-1:0] usart_alt_o,
   output logic [USART_LINES-1:0] usart_alt_oe_o,
   // Timer A waveforms
   input wire logic timer_a_split_i,
   input wire logic [WAVE_LINES-1:0] wave_i,
   input wire logic [WAVE_LINES-1:0] wave_oe_i,
   output logic [WAVE_LINES-1:0] wave_def_o,
   output logic [WAVE_LINES-1:0] wave_def_oe_o,
   output logic [WAVE_LINES-1:0] wave_alt_o,
   output logic [WAVE_LINES-1:0] wave_alt_oe_o,
   // Timer B outputs, bit 0 is the first timer
   input wire logic [TB_LINES-1:0] tb_out_i,
   input wire logic [TB_LINES-1:0] tb_oe_i,
   output logic [TB_LINES-1:0] tb_def_o,
   output logic [TB_LINES-1:0] tb_def_oe_o,
   output logic [TB_LINES-1:0] tb_alt_o,
   output logic [TB_LINES-1:0] tb_alt_oe_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [REG_W-1:0] ctrl_a;
      logic [REG_W-1:0] ctrl_b;
      logic [REG_W-1:0] ctrl_c;
      logic [REG_W-1:0] ctrl_d;
      logic ack;
      logic [DAT_W-1:0] rdata;
      logic [EVENT_LINES-1:0] ev_out;
      logic [EVENT_LINES-1:0] ev_oe;
   } router_state_t;

   router_state_t st_r;
   router_state_t st_nxt;

   logic [IDX_W-1:0] idx;
   logic req;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   function automatic logic [REG_W-1:0] reg_mask(input logic [IDX_W-1:0] i);
      case (i)
         IDX_CTRL_A: reg_mask = CTRL_A_MASK;
         IDX_CTRL_B: reg_mask = CTRL_B_MASK;
         IDX_CTRL_C: reg_mask = CTRL_C_MASK;
         IDX_CTRL_D: reg_mask = CTRL_D_MASK;
         default: reg_mask = 8'h00;
      endcase
   endfunction

   function automatic logic [REG_W-1:0] reg_read(
      input logic [IDX_W-1:0] i,
      input router_state_t s
   );
      case (i)
         IDX_CTRL_A: reg_read = s.ctrl_a;
         IDX_CTRL_B: reg_read = s.ctrl_b;
         IDX_CTRL_C: reg_read = s.ctrl_c;
         IDX_CTRL_D: reg_read = s.ctrl_d;
         default: reg_read = 8'h00;
      endcase
   endfunction

   assign idx = wb_adr_i[ADR_W-1:2];
   // Not yet acknowledged: one answer per request
   assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;

   // ---------------------------------------------------------------
   // Event pin enables
   // ---------------------------------------------------------------
   logic [EVENT_LINES-1:0] ev_en;

   for (genvar g = 0; g < EVENT_LINES; g++) begin : g_event_en
      assign ev_en[g] = st_r.ctrl_a[A_EVENT_LSB + g];
   end

   // ---------------------------------------------------------------
   // Bus slave and event gating
   // ---------------------------------------------------------------
   always_comb begin
      logic [REG_W-1:0] wbyte;
      logic wr;
      logic rd;
      wbyte = wb_dat_i[REG_W-1:0] & reg_mask(idx);
      wr = req & wb_we_i & wb_sel_i[0];
      rd = req & ~wb_we_i;
      st_nxt = st_r;
      // Ack gates its own request, so a held request is answered every second cycle
      st_nxt.ack = req;
      st_nxt.rdata = '0;
      if (rd) begin
         st_nxt.rdata = {24'h000000, reg_read(idx, st_r)};
      end
      if (wr) begin
         case (idx)
            IDX_CTRL_A: st_nxt.ctrl_a = wbyte;
            IDX_CTRL_B: st_nxt.ctrl_b = wbyte;
            IDX_CTRL_C: st_nxt.ctrl_c = wbyte;
            IDX_CTRL_D: st_nxt.ctrl_d = wbyte;
            default: st_nxt.ctrl_a = st_r.ctrl_a;
         endcase
      end
      // Disabled event pins are released and held low
      st_nxt.ev_oe = ev_en;
      st_nxt.ev_out = event_i & ev_en;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = st_r.rdata;
   assign event_pin_o = st_r.ev_out;
   assign event_pin_oe_o = st_r.ev_oe;

   // ---------------------------------------------------------------
   // Selections
   // ---------------------------------------------------------------
   // Both pins of a pair follow one registered select bit,
   // so this block never drives the two pins of a pair at once.
   logic [LUT_LINES-1:0] lut_sel;
   logic [WAVE_LINES-1:0] wave_sel;
   logic [TWI_LINES-1:0] twi_sel;
   logic [SPI_LINES-1:0] spi_sel;
   logic [USART_LINES-1:0] usart_sel;
   logic [TB_LINES-1:0] tb_sel;

   assign lut_sel[1] = st_r.ctrl_a[A_LOGIC_TABLE_ONE_ALT_BIT];
   assign lut_sel[0] = st_r.ctrl_a[A_LOGIC_TABLE_ZERO_ALT_BIT];
   assign twi_sel = {TWI_LINES{st_r.ctrl_b[B_TWO_WIRE_BIT]}};
   assign spi_sel = {SPI_LINES{st_r.ctrl_b[B_SPI_BIT]}};
   assign usart_sel = {USART_LINES{st_r.ctrl_b[B_USART_BIT]}};
   assign tb_sel = st_r.ctrl_d[D_TB_LSB +: TB_LINES];

   for (genvar g = 0; g < WAVE_HALF; g++) begin : g_wave_sel
      assign wave_sel[g] = st_r.ctrl_c[C_WAVE_LO_LSB + g];
      // Upper waveforms stay on default pins in normal mode
      assign wave_sel[WAVE_HALF + g] = st_r.ctrl_c[C_WAVE_HI_LSB + g] & timer_a_split_i;
   end

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_sync;

   // Pin levels come from the port logic, outside this clock's timing
   assign pins_raw = {usart_alt_in_i, usart_def_in_i, spi_alt_in_i, spi_def_in_i,
      twi_alt_in_i, twi_def_in_i};

   pin_sync #(
      .WIDTH(SYNC_W)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pins_raw),
      .sync_o(pins_sync)
   );

   // ---------------------------------------------------------------
   // Routing groups
   // ---------------------------------------------------------------
   // Table outputs have no enable of their own: the chosen pin drives whenever out of reset
   route_group #(
      .LINES(LUT_LINES)
   ) u_lut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(lut_sel),
      .periph_out_i(lut_out_i),
      .periph_oe_i({LUT_LINES{1'b1}}),
      .def_in_i('0),
      .alt_in_i('0),
      .periph_in_o(),
      .def_out_o(lut_def_o),
      .def_oe_o(lut_def_oe_o),
      .alt_out_o(lut_alt_o),
      .alt_oe_o(lut_alt_oe_o)
   );

   route_group #(
      .LINES(TWI_LINES)
   ) u_twi (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(twi_sel),
      .periph_out_i(twi_out_i),
      .periph_oe_i(twi_oe_i),
      .def_in_i(pins_sync[0 +: TWI_LINES]),
      .alt_in_i(pins_sync[TWI_LINES +: TWI_LINES]),
      .periph_in_o(twi_in_o),
      .def_out_o(twi_def_o),
      .def_oe_o(twi_def_oe_o),
      .alt_out_o(twi_alt_o),
      .alt_oe_o(twi_alt_oe_o)
   );

   route_group #(
      .LINES(SPI_LINES)
   ) u_spi (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(spi_sel),
      .periph_out_i(spi_out_i),
      .periph_oe_i(spi_oe_i),
      .def_in_i(pins_sync[2*TWI_LINES +: SPI_LINES]),
      .alt_in_i(pins_sync[2*TWI_LINES+SPI_LINES +: SPI_LINES]),
      .periph_in_o(spi_in_o),
      .def_out_o(spi_def_o),
      .def_oe_o(spi_def_oe_o),
      .alt_out_o(spi_alt_o),
      .alt_oe_o(spi_alt_oe_o)
   );

   route_group #(
      .LINES(USART_LINES)
   ) u_usart (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(usart_sel),
      .periph_out_i(usart_out_i),
      .periph_oe_i(usart_oe_i),
      .def_in_i(pins_sync[2*(TWI_LINES+SPI_LINES) +: USART_LINES]),
      .alt_in_i(pins_sync[2*(TWI_LINES+SPI_LINES)+USART_LINES +: USART_LINES]),
      .periph_in_o(usart_in_o),
      .def_out_o(usart_def_o),
      .def_oe_o(usart_def_oe_o),
      .alt_out_o(usart_alt_o),
      .alt_oe_o(usart_alt_oe_o)
   );

   // Output-only groups: pin inputs unused
   route_group #(
      .LINES(WAVE_LINES)
   ) u_wave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(wave_sel),
      .periph_out_i(wave_i),
      .periph_oe_i(wave_oe_i),
      .def_in_i('0),
      .alt_in_i('0),
      .periph_in_o(),
      .def_out_o(wave_def_o),
      .def_oe_o(wave_def_oe_o),
      .alt_out_o(wave_alt_o),
      .alt_oe_o(wave_alt_oe_o)
   );

   route_group #(
      .LINES(TB_LINES)
   ) u_tb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(tb_sel),
      .periph_out_i(tb_out_i),
      .periph_oe_i(tb_oe_i),
      .def_in_i('0),
      .alt_in_i('0),
      .periph_in_o(),
      .def_out_o(tb_def_o),
      .def_oe_o(tb_def_oe_o),
      .alt_out_o(tb_alt_o),
      .alt_oe_o(tb_alt_oe_o)
   );

endmodule

/* File: common/pin_router_pkg.sv */
// Constants shared by the peripheral pin router files
package pin_router_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADR_W = 5;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 3;

   // Register index; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL_A = 3'h0;
   localparam logic [IDX_W-1:0] IDX_CTRL_B = 3'h1;
   localparam logic [IDX_W-1:0] IDX_CTRL_C = 3'h2;
   localparam logic [IDX_W-1:0] IDX_CTRL_D = 3'h3;

   // ---------------------------------------------------------------
   // Reset values and writable bits
   // ---------------------------------------------------------------
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [REG_W-1:0] CTRL_A_MASK = 8'h37;
   localparam logic [REG_W-1:0] CTRL_B_MASK = 8'h15;
   localparam logic [REG_W-1:0] CTRL_C_MASK = 8'h3f;
   localparam logic [REG_W-1:0] CTRL_D_MASK = 8'h03;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int A_LOGIC_TABLE_ONE_ALT_BIT = 5;
   localparam int A_LOGIC_TABLE_ZERO_ALT_BIT = 4;
   localparam int A_EVENT_LSB = 0;
   localparam int B_TWO_WIRE_BIT = 4;
   localparam int B_SPI_BIT = 2;
   localparam int B_USART_BIT = 0;
   localparam int C_WAVE_LO_LSB = 0;
   localparam int C_WAVE_HI_LSB = 3;
   localparam int D_TB_LSB = 0;

   // ---------------------------------------------------------------
   // Line counts per group
   // ---------------------------------------------------------------
   localparam int EVENT_LINES = 3;
   localparam int LUT_LINES = 2;
   localparam int TWI_LINES = 2;
   localparam int SPI_LINES = 4;
   localparam int USART_LINES = 4;
   localparam int WAVE_LINES = 6;
   localparam int WAVE_HALF = 3;
   localparam int TB_LINES = 2;
   localparam int SYNC_W = 2 * (TWI_LINES + SPI_LINES + USART_LINES);

endpackage

/* File: logic/pin_sync.sv */
// Two-flop synchroniser for pin inputs
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = async_i;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.sync;

endmodule

/* File: logic/route_group.sv */
// Default/alternative pin steering for a group of peripheral lines
module route_group #(
   parameter int LINES = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [LINES-1:0] sel_i,
   input wire logic [LINES-1:0] periph_out_i,
   input wire logic [LINES-1:0] periph_oe_i,
   input wire logic [LINES-1:0] def_in_i,
   input wire logic [LINES-1:0] alt_in_i,
   output logic [LINES-1:0] periph_in_o,
   output logic [LINES-1:0] def_out_o,
   output logic [LINES-1:0] def_oe_o,
   output logic [LINES-1:0] alt_out_o,
   output logic [LINES-1:0] alt_oe_o
);

   typedef struct packed {
      logic [LINES-1:0] def_out;
      logic [LINES-1:0] def_oe;
      logic [LINES-1:0] alt_out;
      logic [LINES-1:0] alt_oe;
      logic [LINES-1:0] periph_in;
   } route_state_t;

   route_state_t st_r;
   route_state_t st_nxt;

   // Unselected pin is released, with its output and enable both held low
   always_comb begin
      st_nxt = st_r;
      st_nxt.def_out = periph_out_i & ~sel_i;
      st_nxt.def_oe = periph_oe_i & ~sel_i;
      st_nxt.alt_out = periph_out_i & sel_i;
      st_nxt.alt_oe = periph_oe_i & sel_i;
      st_nxt.periph_in = (alt_in_i & sel_i) | (def_in_i & ~sel_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign def_out_o = st_r.def_out;
   assign def_oe_o = st_r.def_oe;
   assign alt_out_o = st_r.alt_out;
   assign alt_oe_o = st_r.alt_oe;
   assign periph_in_o = st_r.periph_in;

endmodule

/* File: tb/pin_router_asserts.sv */
// Port-level assertions for the peripheral pin router
module pin_router_asserts
   import pin_router_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [2:0] event_i,
   input wire logic [2:0] event_pin_o,
   input wire logic [2:0] event_pin_oe_o,
   input wire logic [1:0] lut_def_oe_o,
   input wire logic [1:0] lut_alt_oe_o,
   input wire logic [3:0] spi_out_i,
   input wire logic [3:0] spi_def_o,
   input wire logic [3:0] spi_alt_o,
   input wire logic timer_a_split_i,
   input wire logic [5:0] wave_oe_i,
   input wire logic [5:0] wave_alt_oe_o,
   input wire logic [1:0] tb_oe_i,
   input wire logic [1:0] tb_alt_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // Shadow of the control registers
   // ----------------------------------------
   logic [7:0] sh_r [4];
   logic [7:0] rd_r;
   logic live_r;
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [2:0] idx = wb_adr_i[4:2];

   // Masks kept apart from the package so a wrong constant there still shows
   function automatic logic [7:0] msk(input logic [2:0] i);
      case (i)
         3'h0: return 8'h37;
         3'h1: return 8'h15;
         3'h2: return 8'h3f;
         3'h3: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction

   always_ff @(posedge clk_i) begin
      live_r <= ~rst_i;
      if (rst_i) begin
         sh_r <= '{default: 8'h00};
         rd_r <= 8'h00;
      end else begin
         if (req && wb_we_i && wb_sel_i[0] && !wb_adr_i[4]) begin
            sh_r[idx[1:0]] <= wb_dat_i[7:0] & msk(idx);
         end
         rd_r <= wb_adr_i[4] ? 8'h00 : sh_r[idx[1:0]];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   a_ack_pulse: assert property (s_take |=> s_pulse)
      else $error("ack is not a single pulse after a request");
   a_ack_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without a request");
   a_read_data: assert property (s_take ##0 !wb_we_i |=> wb_dat_o == {24'h0, rd_r})
      else $error("read data differs from the register");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_event_gate: assert property (event_pin_oe_o == $past(sh_r[0][2:0])
      && event_pin_o == ($past(event_i) & $past(sh_r[0][2:0])))
      else $error("event pin gating wrong");
   a_lut_steer: assert property (live_r |-> lut_alt_oe_o == $past(sh_r[0][5:4])
      && lut_def_oe_o == ~$past(sh_r[0][5:4]))
      else $error("logic table pin choice wrong");
   a_spi_steer: assert property (live_r |->
      spi_alt_o == ($past(spi_out_i) & {4{$past(sh_r[1][2])}})
      && spi_def_o == ($past(spi_out_i) & ~{4{$past(sh_r[1][2])}}))
      else $error("spi pin choice wrong");
   a_wave_split: assert property (live_r |-> wave_alt_oe_o == ($past(wave_oe_i)
      & {$past(sh_r[2][5:3]) & {3{$past(timer_a_split_i)}}, $past(sh_r[2][2:0])}))
      else $error("waveform pin choice wrong");
   a_timerb_alt: assert property (live_r |->
      tb_alt_oe_o == ($past(tb_oe_i) & $past(sh_r[3][1:0])))
      else $error("timer b pin choice wrong");
endmodule

bind peripheral_pin_router pin_router_asserts chk (.*);

/* File: tb/periph_model.sv */
// Stand-in for the peripherals and port pin logic around the router
module periph_model (
   input wire logic clk_i,
   output logic [60:0] drive_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Odd step keeps most lines toggling; still lines would hide stuck routes
   initial drive_o = 61'h0;
   always @(posedge clk_i) begin
      drive_o <= drive_o + 61'h123456789abcdef;
   end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the peripheral pin router
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timer_a_split_i;
   logic [4:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0] wb_sel_i;
   logic [2:0] event_i, event_pin_o, event_pin_oe_o;
   logic [1:0] lut_out_i, lut_def_o, lut_def_oe_o, lut_alt_o, lut_alt_oe_o;
   logic [1:0] twi_out_i, twi_oe_i, twi_in_o, twi_def_in_i, twi_def_o, twi_def_oe_o;
   logic [1:0] twi_alt_in_i, twi_alt_o, twi_alt_oe_o;
   logic [3:0] spi_out_i, spi_oe_i, spi_in_o, spi_def_in_i, spi_def_o, spi_def_oe_o;
   logic [3:0] spi_alt_in_i, spi_alt_o, spi_alt_oe_o;
   logic [3:0] usart_out_i, usart_oe_i, usart_in_o, usart_def_in_i, usart_def_o;
   logic [3:0] usart_def_oe_o, usart_alt_in_i, usart_alt_o, usart_alt_oe_o;
   logic [5:0] wave_i, wave_oe_i, wave_def_o, wave_def_oe_o, wave_alt_o, wave_alt_oe_o;
   logic [1:0] tb_out_i, tb_oe_i, tb_def_o, tb_def_oe_o, tb_alt_o, tb_alt_oe_o;
   logic [60:0] d, d1, d2, d3;
   logic [7:0] m [4];
   logic s1;
   logic chk_on = 1'b0;
   int error_cnt = 0;
   int checks_done = 0;
   // Address, select, write data, expected readback
   logic [27:0] rows [15] = '{28'h001ff37, 28'h041ff15, 28'h081ff3f, 28'h0c1ff03,
      28'h101ff00, 28'h0000037, 28'h001ca02, 28'h041ea00, 28'h0811515, 28'h0c10202,
      28'h1c1ff00, 28'h0012121, 28'h0310000, 28'h001ff37, 28'h041ff15};

   assign {tb_oe_i, tb_out_i, wave_oe_i, wave_i, usart_alt_in_i, usart_def_in_i,
      usart_oe_i, usart_out_i, spi_alt_in_i, spi_def_in_i, spi_oe_i, spi_out_i,
      twi_alt_in_i, twi_def_in_i, twi_oe_i, twi_out_i, lut_out_i, event_i} = d;
   wire [31:0] ev_v = 32'({event_pin_o, event_pin_oe_o});
   wire [31:0] lut_v = 32'({lut_def_o, lut_def_oe_o, lut_alt_o, lut_alt_oe_o});
   wire [31:0] twi_v = 32'({twi_def_o, twi_def_oe_o, twi_alt_o, twi_alt_oe_o});
   wire [31:0] spi_v = 32'({spi_def_o, spi_def_oe_o, spi_alt_o, spi_alt_oe_o});
   wire [31:0] usart_v = 32'({usart_def_o, usart_def_oe_o, usart_alt_o, usart_alt_oe_o});
   wire [31:0] wave_v = 32'({wave_def_o, wave_def_oe_o, wave_alt_o, wave_alt_oe_o});
   wire [31:0] tmr_v = 32'({tb_def_o, tb_def_oe_o, tb_alt_o, tb_alt_oe_o});
   wire [31:0] rst_v = 32'({wb_ack_o, wb_dat_o[7:0], event_pin_oe_o, lut_def_oe_o,
      lut_alt_oe_o, spi_def_oe_o, wave_alt_oe_o, tb_alt_oe_o});
   wire [9:0] in_e = {m[1][4] ? d3[12:11] : d3[10:9], m[1][2] ? d3[28:25] : d3[24:21],
      m[1][0] ? d3[44:41] : d3[40:37]};

   periph_model model (.clk_i(clk_i), .drive_o(d));
   peripheral_pin_router DUT (.*);

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] sp(input logic [5:0] s, o, e, input int w);
      logic [31:0] k;
      k = (32'h1 << w) - 32'h1;
      return (32'(o & ~s) & k) << (3 * w) | (32'(e & ~s) & k) << (2 * w)
         | (32'(o & s) & k) << w | (32'(e & s) & k);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bus(input logic [4:0] a, input logic [3:0] s, input logic w,
      input logic [7:0] wd, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, wd};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Split mode flips mid-window so both timer modes are seen per setting
   task automatic route_check();
      chk_on = 1'b1;
      repeat (4) @(posedge clk_i);
      timer_a_split_i <= ~timer_a_split_i;
      repeat (5) @(posedge clk_i);
      chk_on = 1'b0;
   endtask

   task automatic reset_test();
      for (int i = 0; i < 4; i++) begin
         bus(5'(4 * i), 4'hf, 1'b0, 8'h00, q);
         check(q, 32'h0);
      end
      route_check();
      $display("Reset test done");
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check(rst_v, 32'h0);
      @(posedge clk_i);
      rst_i <= 1'b0;
      m = '{default: 8'h00};
      reset_test();
   endtask

   // ----------------------------------------
   // Routing comparison, one edge behind; pin inputs three edges behind
   // ----------------------------------------
   always @(negedge clk_i) begin
      if (chk_on) begin
         check(ev_v, 32'({d1[2:0] & m[0][2:0], m[0][2:0]}));
         check(lut_v, sp(6'(m[0][5:4]), 6'(d1[4:3]), 6'h3, 2));
         check(twi_v, sp({6{m[1][4]}}, 6'(d1[6:5]), 6'(d1[8:7]), 2));
         check(spi_v, sp({6{m[1][2]}}, 6'(d1[16:13]), 6'(d1[20:17]), 4));
         check(usart_v, sp({6{m[1][0]}}, 6'(d1[32:29]), 6'(d1[36:33]), 4));
         check(wave_v, sp({m[2][5:3] & {3{s1}}, m[2][2:0]}, d1[50:45], d1[56:51], 6));
         check(tmr_v, sp(6'(m[3][1:0]), 6'(d1[58:57]), 6'(d1[60:59]), 2));
         check(32'({twi_in_o, spi_in_o, usart_in_o}), 32'(in_e));
      end
      d3 = d2;
      d2 = d1;
      d1 = d;
      s1 = timer_a_split_i;
   end

   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 5'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      timer_a_split_i = 1'b0;
      m = '{default: 8'h00};
      do_reset();
      foreach (rows[i]) begin
         bus(rows[i][24:20], rows[i][19:16], 1'b1, rows[i][15:8], q);
         bus(rows[i][24:20], 4'h1, 1'b0, 8'h00, q);
         check(q, 32'(rows[i][7:0]));
         if (!rows[i][24]) m[rows[i][23:22]] = rows[i][7:0];
         route_check();
         $display("Row %0d done", i);
      end
      do_reset();
      results();
   end

   // Run needs about 280 cycles; some fourteen times that before giving up
   initial begin
      #400000;
      error_cnt++;
      results();
   end
endmodule
